/* src/cmp_map.svh */
// offsets, field positions, reset values and timing counts of the comparator control block
// What this block does
// R1 - the control interface is a 16-bit control register, bits 15 to 11 reserved, plus status and mask registers.
// R2 - bit 10 powers the comparator up when written 1 and disables it when written 0.
// R3 - turning the comparator on raises a comparator event which software then clears.
// R4 - bits 9:8 pick the negative input: half supply, channel three, scaled reference, reserved.
// R5 - bits 7:6 route the output: 00/01 nowhere, 10 to the logic array, 11 to the interrupt.
// R6 - bit 5 low gives a high output when plus exceeds minus, bit 5 high inverts that.
// R7 - bits 4:3 pick the speed: 00 slow signal-dependent, 11 fast, 01 and 10 reserved.
// R8 - bit 2 turns hysteresis on and drives the matching analogue control line.
// R9 - hardware sets the rising-edge flag at bit 1 on a rising transition of the output.
// R10 - writing one to bit 1 clears the rising-edge flag, writing zero leaves it.
// R11 - hardware sets the falling-edge flag at bit 0 on a falling transition of the output.
// R12 - writing one to bit 0 clears the falling-edge flag, writing zero leaves it.
// R13 - reserved bits read zero and ignore writes; the output is synchronised before edges.
// R14 - the positive input is the analogue pin shared with converter channel two.
// R15 - the output also reaches the logic array, the conversion trigger and an output pin.
`ifndef CMP_MAP_SVH
`define CMP_MAP_SVH

`define CMP_CTRL_OFFSET     12'h000
`define CMP_STATUS_OFFSET   12'h004
`define CMP_MASK_OFFSET     12'h008
`define CMP_ON_BIT          10
`define CMP_NEG_SEL_HI      9
`define CMP_NEG_SEL_LO      8
`define CMP_ROUTE_HI        7
`define CMP_ROUTE_LO        6
`define CMP_POL_BIT         5
`define CMP_RESP_HI         4
`define CMP_RESP_LO         3
`define CMP_HYST_BIT        2
`define CMP_RISE_BIT        1
`define CMP_FALL_BIT        0
`define CMP_CTRL_WMASK      16'h07FC
`define CMP_CTRL_RESET      16'h0000
`define CMP_IRQ_RESET       2'h0
`define CMP_EVENTS          2
`define CMP_SETTLE_NS       100
`define CMP_CLK_NS          25
`define CMP_SETTLE_CYCLES   ((`CMP_SETTLE_NS + `CMP_CLK_NS - 1) / `CMP_CLK_NS)

`endif

/* src/cmp_pkg.sv */
// types shared by the comparator control block
package cmp_pkg;

  typedef enum logic [1:0] {
    neg_half_supply = 2'h0,
    neg_channel_three = 2'h1,
    neg_scaled_ref = 2'h2,
    neg_reserved = 2'h3
  } neg_sel_t;

  typedef enum logic [1:0] {
    route_off_a = 2'h0,
    route_off_b = 2'h1,
    route_logic_array = 2'h2,
    route_interrupt = 2'h3
  } route_t;

  typedef enum logic [1:0] {
    resp_slow = 2'h0,
    resp_res_a = 2'h1,
    resp_res_b = 2'h2,
    resp_fast = 2'h3
  } resp_t;

  // analogue-side controls carried as one group
  typedef struct packed {
    logic     comparator_on;
    neg_sel_t negative_input_select;
    logic     hysteresis_on;
    resp_t    response_time_select;
  } analog_ctrl_t;

  // comparator output fan-out
  typedef struct packed {
    logic to_logic_array;
    logic adc_trigger;
    logic output_pin;
  } cmp_fanout_t;

  typedef enum logic [2:0] {
    st_off = 3'b001,
    st_settle = 3'b010,
    st_run = 3'b100
  } pwr_state_t;

endpackage

/* src/cmp_edge_detect.sv */
// synchroniser and edge detector for the raw comparator output
`timescale 1ns/10ps
`include "cmp_map.svh"
module cmp_edge_detect (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic raw_in,
  output logic      level,
  output logic      rise,
  output logic      fall
);
  logic meta_reg;
  logic sync_reg;
  logic prev_reg;

  // two-flop synchroniser, then one delay for the edge compare
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_reg <= 1'b0;
      sync_reg <= 1'b0;
      prev_reg <= 1'b0;
    end else begin
      meta_reg <= raw_in; // [R13]
      sync_reg <= meta_reg;
      prev_reg <= sync_reg;
    end
  end

  assign level = sync_reg;
  assign rise = sync_reg & ~prev_reg; // [R9]
  assign fall = ~sync_reg & prev_reg; // [R11]
endmodule // cmp_edge_detect

/* src/cmp_ctrl.sv */
// comparator control register bank with apb slave and interrupt logic
`timescale 1ns/10ps
`include "cmp_map.svh"
module cmp_ctrl #(
  parameter int settle_cycles = `CMP_SETTLE_CYCLES
) (
  input  wire logic                 pclk,
  input  wire logic                 presetn,
  input  wire logic                 psel,
  input  wire logic                 penable,
  input  wire logic                 pwrite,
  input  wire logic [11:0]          paddr,
  input  wire logic [31:0]          pwdata,
  output logic      [31:0]          prdata,
  output logic                      pready,
  output logic                      pslverr,
  input  wire logic                 comparator_raw,
  output cmp_pkg::analog_ctrl_t     analog_ctrl,
  output logic                      positive_input_from_channel_two,
  output cmp_pkg::cmp_fanout_t      fanout,
  output logic                      irq
);
  logic [15:0]               ctrl_reg;
  logic [1:0]                flags_reg;
  logic [1:0]                mask_reg;
  logic [1:0]                irq_stat_reg;
  cmp_pkg::pwr_state_t       state_reg;
  logic [7:0]                settle_reg;
  logic                      rise;
  logic                      fall;
  logic                      level;
  logic                      polar;
  logic                      setup;
  logic                      wr_acc;
  logic                      rd_acc;
  logic                      hit;
  logic                      on_event;
  logic                      on_irq;
  logic [1:0]                ev;
  logic [1:0]                wclr;
  logic                      route_irq;
  logic                      route_pla;

  cmp_edge_detect u_edge (
    .pclk    (pclk),
    .presetn (presetn),
    .raw_in  (polar),
    .level   (level),
    .rise    (rise),
    .fall    (fall)
  );

  // polarity applied ahead of the synchroniser; bit 5 flips the sense
  assign polar = comparator_raw ^ ctrl_reg[`CMP_POL_BIT]; // [R6]

  // apb decode; the slave answers in the first access cycle
  assign setup = psel & ~penable;
  assign wr_acc = psel & penable & pwrite & pready;
  assign rd_acc = setup & ~pwrite;
  assign hit = (paddr == `CMP_CTRL_OFFSET) || (paddr == `CMP_STATUS_OFFSET) ||
               (paddr == `CMP_MASK_OFFSET);
  assign route_irq = (ctrl_reg[`CMP_ROUTE_HI:`CMP_ROUTE_LO] == cmp_pkg::route_interrupt);
  assign route_pla = (ctrl_reg[`CMP_ROUTE_HI:`CMP_ROUTE_LO] == cmp_pkg::route_logic_array);

  // a 0->1 write on the enable bit counts as an event
  assign on_event = wr_acc && (paddr == `CMP_CTRL_OFFSET) && pwdata[`CMP_ON_BIT] &&
                    !ctrl_reg[`CMP_ON_BIT]; // [R3]
  // the enable event obeys the routing written with it, so one write can arm both
  assign on_irq = on_event &&
                  (pwdata[`CMP_ROUTE_HI:`CMP_ROUTE_LO] == cmp_pkg::route_interrupt); // [R5]
  assign wclr = (wr_acc && (paddr == `CMP_CTRL_OFFSET)) ?
                pwdata[`CMP_RISE_BIT:`CMP_FALL_BIT] : 2'b00;

  // edges only count once the comparator has settled after power up
  assign ev = (state_reg == cmp_pkg::st_run) ? {rise, fall} : 2'b00;

  // power sequencing: off, settle, run
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= cmp_pkg::st_off;
      settle_reg <= 8'h00;
    end else begin
      case (state_reg)
        cmp_pkg::st_off: begin
          if (ctrl_reg[`CMP_ON_BIT]) begin
            state_reg <= cmp_pkg::st_settle;
            settle_reg <= 8'h00;
          end
        end
        cmp_pkg::st_settle: begin
          if (!ctrl_reg[`CMP_ON_BIT]) begin
            state_reg <= cmp_pkg::st_off;
          end else if (settle_reg >= 8'(settle_cycles - 1)) begin
            state_reg <= cmp_pkg::st_run;
          end else begin
            settle_reg <= settle_reg + 8'h01;
          end
        end
        cmp_pkg::st_run: begin
          if (!ctrl_reg[`CMP_ON_BIT]) begin
            state_reg <= cmp_pkg::st_off;
          end
        end
        default: begin
          state_reg <= cmp_pkg::st_off;
        end
      endcase
    end
  end

  // control fields; reserved bits never stored
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg <= `CMP_CTRL_RESET;
    end else if (wr_acc && (paddr == `CMP_CTRL_OFFSET)) begin
      ctrl_reg <= pwdata[15:0] & `CMP_CTRL_WMASK; // [R1] [R2] [R4] [R7] [R8] [R13]
    end
  end

  // edge flags; a set in the same cycle as a clear wins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flags_reg <= 2'b00;
    end else begin
      flags_reg[1] <= ev[1] | on_event | (flags_reg[1] & ~wclr[1]); // [R9] [R10] [R3]
      flags_reg[0] <= ev[0] | (flags_reg[0] & ~wclr[0]); // [R11] [R12]
    end
  end

  // sticky interrupt status, gated by routing; write one clears
  generate
    for (genvar i = 0; i < `CMP_EVENTS; i++) begin : g_irq
      logic src;
      logic clr;
      assign src = (ev[i] & route_irq) | (i == 1 ? on_irq : 1'b0); // [R5] [R3]
      assign clr = wr_acc && (paddr == `CMP_STATUS_OFFSET) && pwdata[i];
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          irq_stat_reg[i] <= 1'b0;
        end else begin
          irq_stat_reg[i] <= src | (irq_stat_reg[i] & ~clr);
        end
      end
    end
  endgenerate

  // mask register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mask_reg <= `CMP_IRQ_RESET;
    end else if (wr_acc && (paddr == `CMP_MASK_OFFSET)) begin
      mask_reg <= pwdata[1:0];
    end
  end

  // apb answer: ready in the access cycle, error on unmapped address
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= setup;
      pslverr <= setup & ~hit;
      if (rd_acc) begin
        case (paddr)
          `CMP_CTRL_OFFSET: prdata <= {16'h0000, ctrl_reg[15:2], flags_reg};
          `CMP_STATUS_OFFSET: prdata <= {30'h0000_0000, irq_stat_reg};
          `CMP_MASK_OFFSET: prdata <= {30'h0000_0000, mask_reg};
          default: prdata <= 32'h0000_0000;
        endcase
      end else begin
        prdata <= 32'h0000_0000;
      end
    end
  end

  // registered outputs toward the analogue side and the fan-out
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      analog_ctrl <= '0;
      positive_input_from_channel_two <= 1'b0;
      fanout <= '0;
      irq <= 1'b0;
    end else begin
      analog_ctrl.comparator_on <= ctrl_reg[`CMP_ON_BIT]; // [R2]
      analog_ctrl.negative_input_select <=
        cmp_pkg::neg_sel_t'(ctrl_reg[`CMP_NEG_SEL_HI:`CMP_NEG_SEL_LO]); // [R4]
      analog_ctrl.hysteresis_on <= ctrl_reg[`CMP_HYST_BIT]; // [R8]
      analog_ctrl.response_time_select <=
        cmp_pkg::resp_t'(ctrl_reg[`CMP_RESP_HI:`CMP_RESP_LO]); // [R7]
      positive_input_from_channel_two <= ctrl_reg[`CMP_ON_BIT]; // [R14]
      fanout.to_logic_array <= level & route_pla & ctrl_reg[`CMP_ON_BIT]; // [R5] [R15]
      fanout.adc_trigger <= rise & ctrl_reg[`CMP_ON_BIT]; // [R15]
      fanout.output_pin <= level & ctrl_reg[`CMP_ON_BIT]; // [R15]
      irq <= |(irq_stat_reg & mask_reg);
    end
  end
endmodule // cmp_ctrl

/* testbench/cmp_ctrl_sva.sv */
// port assertions for the comparator control block
`timescale 1ns/10ps
module cmp_ctrl_sva (
  input wire logic                  pclk,
  input wire logic                  presetn,
  input wire logic                  psel,
  input wire logic                  penable,
  input wire logic                  pwrite,
  input wire logic [11:0]           paddr,
  input wire logic [31:0]           pwdata,
  input wire logic [31:0]           prdata,
  input wire logic                  pready,
  input wire logic                  pslverr,
  input wire cmp_pkg::analog_ctrl_t analog_ctrl,
  input wire logic                  positive_input_from_channel_two,
  input wire cmp_pkg::cmp_fanout_t  fanout,
  input wire logic                  irq
);
  logic [15:0] wd_last;
  wire         wr_ctrl = psel & penable & pready & pwrite & (paddr == 12'h000);
  // last control word, so copies may lag one cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) wd_last <= 16'h0000;
    else if (wr_ctrl) wd_last <= pwdata[15:0];
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_setup; psel && !penable; endsequence
  sequence s_ctrl_wr; wr_ctrl; endsequence
  chk_ready_once: assert property (s_setup |=> pready ##1 !pready)
    else $error("pready is not a single pulse");
  chk_on_copy: assert property (s_ctrl_wr |-> ##[1:2] analog_ctrl.comparator_on == wd_last[10])
    else $error("enable line does not follow bit 10");
  chk_neg_copy: assert property (s_ctrl_wr |-> ##[1:2] analog_ctrl.negative_input_select == wd_last[9:8])
    else $error("negative select does not follow bits 9:8");
  chk_resp_copy: assert property (s_ctrl_wr |-> ##[1:2] analog_ctrl.response_time_select == wd_last[4:3])
    else $error("response select does not follow bits 4:3");
  chk_hyst_copy: assert property (s_ctrl_wr |-> ##[1:2] analog_ctrl.hysteresis_on == wd_last[2])
    else $error("hysteresis line does not follow bit 2");
  chk_chan_two: assert property ($rose(analog_ctrl.comparator_on) |-> ##[0:1] positive_input_from_channel_two)
    else $error("shared pin not selected when on");
  chk_pin_off: assert property (!analog_ctrl.comparator_on [*3] |-> !fanout.output_pin)
    else $error("output pin high while off");
  chk_pla_route: assert property (fanout.to_logic_array |-> fanout.output_pin && $past(wd_last[7:6]) == 2'b10)
    else $error("logic array fed without output");
  chk_err_ready: assert property (pslverr |-> pready && prdata == 32'h0)
    else $error("error response malformed");
  chk_trig_pulse: assert property (fanout.adc_trigger |=> !fanout.adc_trigger)
    else $error("trigger longer than one cycle");
endmodule // cmp_ctrl_sva
bind cmp_ctrl cmp_ctrl_sva i_sva (
  .pclk                            (pclk),
  .presetn                         (presetn),
  .psel                            (psel),
  .penable                         (penable),
  .pwrite                          (pwrite),
  .paddr                           (paddr),
  .pwdata                          (pwdata),
  .prdata                          (prdata),
  .pready                          (pready),
  .pslverr                         (pslverr),
  .analog_ctrl                     (analog_ctrl),
  .positive_input_from_channel_two (positive_input_from_channel_two),
  .fanout                          (fanout),
  .irq                             (irq)
);

/* testbench/cmp_analog_model.sv */
// behavioural analogue comparator on the far side of the block
`timescale 1ns/10ps
module cmp_analog_model (
  input  wire logic                  plus_above,
  input  wire cmp_pkg::analog_ctrl_t analog_ctrl,
  input  wire logic                  channel_two_sel,
  output logic                       comparator_raw
);
  // unpowered or unselected comparator sinks its output low
  assign comparator_raw = analog_ctrl.comparator_on & channel_two_sel & plus_above;
endmodule // cmp_analog_model

/* testbench/comparator_control_interface_test.sv */
// self-checking bench for the comparator control block
`timescale 1ns/10ps
`include "cmp_map.svh"
module comparator_control_interface_test;
  logic                  pclk, presetn, psel, penable, pwrite, plus_above;
  logic [11:0]           paddr;
  logic [31:0]           pwdata, prdata, rd;
  logic                  pready, pslverr, irq, err, comparator_raw;
  logic                  positive_input_from_channel_two;
  cmp_pkg::analog_ctrl_t analog_ctrl;
  cmp_pkg::cmp_fanout_t  fanout;
  int                    n_mismatch, compares, cyc;
  cmp_ctrl #(.settle_cycles(2)) i_dut (
    .pclk                            (pclk),
    .presetn                         (presetn),
    .psel                            (psel),
    .penable                         (penable),
    .pwrite                          (pwrite),
    .paddr                           (paddr),
    .pwdata                          (pwdata),
    .prdata                          (prdata),
    .pready                          (pready),
    .pslverr                         (pslverr),
    .comparator_raw                  (comparator_raw),
    .analog_ctrl                     (analog_ctrl),
    .positive_input_from_channel_two (positive_input_from_channel_two),
    .fanout                          (fanout),
    .irq                             (irq)
  );
  cmp_analog_model i_model (.plus_above(plus_above), .analog_ctrl(analog_ctrl),
    .channel_two_sel(positive_input_from_channel_two), .comparator_raw(comparator_raw));
  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end
  // one transfer; a stuck slave is left to the cycle ceiling
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    cmp(rd, exp);
  endtask
  task automatic t_reset;
    rd_chk(`CMP_CTRL_OFFSET, 32'h0);
    rd_chk(`CMP_STATUS_OFFSET, 32'h0);
    rd_chk(`CMP_MASK_OFFSET, 32'h0);
    cmp({31'h0, irq}, 32'h0);
    $display("t_reset done");
  endtask
  task automatic t_fields;
    logic [1:0] c;
    apb(1'b1, `CMP_CTRL_OFFSET, 32'hFFFF_FFDF);
    rd_chk(`CMP_CTRL_OFFSET, 32'h07DE);
    cmp({26'h0, analog_ctrl}, 32'h3F);
    cmp({31'h0, positive_input_from_channel_two}, 32'h1);
    for (int i = 0; i < 4; i++) begin
      c = 2'(i);
      apb(1'b1, `CMP_CTRL_OFFSET, {21'h0, 1'b1, c, 3'h0, c, 3'h0});
      repeat (2) @(posedge pclk);
      cmp({26'h0, analog_ctrl}, {26'h0, 1'b1, c, 1'b0, c});
    end
    rd_chk(`CMP_CTRL_OFFSET, 32'h071A);
    apb(1'b1, `CMP_CTRL_OFFSET, 32'h0402);
    rd_chk(`CMP_CTRL_OFFSET, 32'h0400);
    apb(1'b1, `CMP_STATUS_OFFSET, 32'h3);
    rd_chk(`CMP_STATUS_OFFSET, 32'h0);
    apb(1'b1, `CMP_CTRL_OFFSET, 32'h0);
    rd_chk(`CMP_CTRL_OFFSET, 32'h0);
    $display("t_fields done");
  endtask
  task automatic t_edges;
    apb(1'b1, `CMP_MASK_OFFSET, 32'h3);
    apb(1'b1, `CMP_CTRL_OFFSET, 32'h04C0);
    repeat (2) @(posedge pclk);
    cmp({31'h0, irq}, 32'h1);
    apb(1'b1, `CMP_STATUS_OFFSET, 32'h2);
    apb(1'b1, `CMP_CTRL_OFFSET, 32'h04C2);
    repeat (8) @(posedge pclk);
    cmp({31'h0, irq}, 32'h0);
    plus_above <= 1'b1;
    // two sync flops plus the edge compare, then the registered trigger pulse
    repeat (4) @(posedge pclk);
    cmp({29'h0, fanout}, 32'h3);
    repeat (2) @(posedge pclk);
    rd_chk(`CMP_CTRL_OFFSET, 32'h04C2);
    rd_chk(`CMP_STATUS_OFFSET, 32'h2);
    cmp({29'h0, fanout}, 32'h1);
    plus_above <= 1'b0;
    repeat (6) @(posedge pclk);
    rd_chk(`CMP_CTRL_OFFSET, 32'h04C3);
    cmp({31'h0, irq}, 32'h1);
    apb(1'b1, `CMP_MASK_OFFSET, 32'h0);
    repeat (2) @(posedge pclk);
    cmp({31'h0, irq}, 32'h0);
    apb(1'b1, `CMP_CTRL_OFFSET, 32'h04C1);
    rd_chk(`CMP_CTRL_OFFSET, 32'h04C2);
    apb(1'b1, `CMP_STATUS_OFFSET, 32'h3);
    apb(1'b1, `CMP_CTRL_OFFSET, 32'h04C2);
    rd_chk(`CMP_CTRL_OFFSET, 32'h04C0);
    rd_chk(`CMP_STATUS_OFFSET, 32'h0);
    $display("t_edges done");
  endtask
  task automatic t_polarity;
    apb(1'b1, `CMP_CTRL_OFFSET, 32'h04A0);
    repeat (6) @(posedge pclk);
    rd_chk(`CMP_CTRL_OFFSET, 32'h04A2);
    rd_chk(`CMP_STATUS_OFFSET, 32'h0);
    cmp({29'h0, fanout}, 32'h5);
    apb(1'b1, `CMP_CTRL_OFFSET, 32'h0460);
    repeat (2) @(posedge pclk);
    cmp({29'h0, fanout}, 32'h1);
    apb(1'b1, `CMP_CTRL_OFFSET, 32'h0);
    repeat (4) @(posedge pclk);
    cmp({29'h0, fanout}, 32'h0);
    apb(1'b1, 12'h00C, 32'hFFFF_FFFF);
    cmp({31'h0, err}, 32'h1);
    rd_chk(12'h00C, 32'h0);
    $display("t_polarity done");
  endtask
  // reset in mid-run must drop the three registers, the analogue controls and irq back to idle
  task automatic t_restart;
    apb(1'b1, `CMP_MASK_OFFSET, 32'h3);
    apb(1'b1, `CMP_CTRL_OFFSET, 32'h07FC);
    repeat (2) @(posedge pclk);
    cmp({31'h0, irq}, 32'h1);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    cmp({26'h0, analog_ctrl}, 32'h0);
    presetn <= 1'b1;
    rd_chk(`CMP_CTRL_OFFSET, 32'h0);
    rd_chk(`CMP_STATUS_OFFSET, 32'h0);
    rd_chk(`CMP_MASK_OFFSET, 32'h0);
    cmp({31'h0, irq}, 32'h0);
    $display("t_restart done");
  endtask
  task automatic final_report;
    $display("compares %0d n_mismatch %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // cycle ceiling well above the roughly two hundred cycles the tests need
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 4000) begin
      n_mismatch++;
      $display("CHECK FAILED %0t timeout", $time);
      final_report;
    end
  end
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    plus_above = 1'b0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    t_reset;
    t_fields;
    t_edges;
    t_polarity;
    t_restart;
    final_report;
  end
endmodule // comparator_control_interface_test
